/* src/gsf_pkg.sv */
package gsf_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NUM_PINS = 8;
    localparam int NUM_RAILS = 16;
    localparam int PIN_IDX_W = 3;
    localparam int SEL_PINS = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] REG_POLARITY = 8'h00;
    localparam logic [7:0] REG_FAULT_EN = 8'h04;
    localparam logic [7:0] REG_SHDN_EN = 8'h08;
    localparam logic [7:0] REG_FUNC_SEL = 8'h0C;
    localparam logic [7:0] REG_SHDN_RAILS0 = 8'h10;
    localparam logic [7:0] REG_FAULT_RAILS = 8'h30;
    localparam logic [7:0] REG_PIN_STATE = 8'h34;
    localparam logic [7:0] REG_LATCH_STS = 8'h38;
    localparam logic [7:0] REG_LATCH_CLR = 8'h3C;
    localparam logic [7:0] REG_MARGIN = 8'h40;
    localparam logic [7:0] REG_FAULT_LOG = 8'h44;
    localparam logic [7:0] REG_SHDN_STS = 8'h48;
    localparam logic [7:0] REG_FAULT_RESP = 8'h4C;

    // ----------------------------------------
    // function select fields, 4 bits each: bit 3 valid, bits 2:0 pin
    // ----------------------------------------
    localparam int FSEL_W = 4;
    localparam int FSEL_CLEAR = 0;
    localparam int FSEL_MARGIN_EN = 1;
    localparam int FSEL_MARGIN_LOW = 2;
    localparam int FSEL_DEBUG = 3;
    localparam int FSEL_NUM = 4;
    localparam int FSEL_VALID_BIT = 3;

    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [7:0] RST_POLARITY = 8'hFF;

    typedef enum logic [1:0] {
        GSF_MARGIN_NOMINAL,
        GSF_MARGIN_LOW,
        GSF_MARGIN_HIGH
    } gsf_margin_t;

    typedef enum logic [1:0] {
        GSF_RESP_IGNORE,
        GSF_RESP_IMMEDIATE,
        GSF_RESP_DELAYED
    } gsf_resp_t;
endpackage : gsf_pkg

/* src/gsf_pin_sync.sv */
`timescale 1ns/100ps
module gsf_pin_sync
    import gsf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [gsf_pkg::NUM_PINS-1:0] i_pins,
    input wire logic [gsf_pkg::NUM_PINS-1:0] i_active_high,
    output logic [gsf_pkg::NUM_PINS-1:0] o_asserted,
    output logic [gsf_pkg::NUM_PINS-1:0] o_deassert_pulse
);
    logic [NUM_PINS-1:0] meta_q;
    logic [NUM_PINS-1:0] stable_q;
    logic [NUM_PINS-1:0] asserted_q;
    logic [NUM_PINS-1:0] asserted_d;

    // first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_q <= '0;
            stable_q <= '0;
        end
        else
        begin
            meta_q <= i_pins;
            stable_q <= meta_q;
        end
    end

    // polarity applied after synchronising
    assign asserted_d = ~(stable_q ^ i_active_high);

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            asserted_q <= '0;
        else
            asserted_q <= asserted_d;
    end

    assign o_asserted = asserted_q;
    assign o_deassert_pulse = asserted_q & ~asserted_d;
endmodule : gsf_pin_sync

/* src/gsf_special_inputs.sv */
`timescale 1ns/100ps
// Overview of operation
// - each special function owns one pin; a second claim is ignored
// - with fault enable set, a pin going inactive raises a fault event
// - asserted clear-source pin clears all latched rail status flags
// - margin enable asserted puts margin-enabled rails into margined state
// - margin enable plus low-select asserted drives margined rails low
// - margin enable with low-select inactive drives margined rails high
// - each pin has configurable polarity used for all decisions
// - first three pins also feed the pin-chosen power state selector
// - debug mode stops fault logging except comm faults
// - fault pin output follows faults on its selected rails
// - open-drain output releases pin for a high result
// - shutdown plus fault enable, a response other than ignore, debug off: deassertion shuts selected rails down
// - latched flags hold until bus clear or clear-source pin
// - pin-raised shutdown faults are never retried
module gsf_special_inputs
    import gsf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [gsf_pkg::ADDR_W-1:0] i_addr,
    input wire logic [gsf_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [gsf_pkg::DATA_W-1:0] o_rdata,
    input wire logic [gsf_pkg::NUM_PINS-1:0] i_pins,
    input wire logic [gsf_pkg::NUM_RAILS-1:0] i_rail_fault,
    input wire logic [gsf_pkg::NUM_RAILS-1:0] i_rail_latch_set,
    input wire logic [gsf_pkg::NUM_RAILS-1:0] i_rail_margin_en,
    input wire logic i_fault_event,
    input wire logic i_fault_warn,
    input wire logic i_comm_fault,
    output logic [gsf_pkg::NUM_RAILS-1:0] o_latched_status,
    output logic [gsf_pkg::NUM_RAILS-1:0] o_margin_low,
    output logic [gsf_pkg::NUM_RAILS-1:0] o_margin_high,
    output logic [gsf_pkg::NUM_RAILS-1:0] o_rail_shutdown,
    output logic o_shutdown_delayed,
    output logic o_retry_allowed,
    output logic [gsf_pkg::SEL_PINS-1:0] o_state_select,
    output logic o_pin_fault,
    output logic o_bus_alert,
    output logic o_fault_resp_en,
    output logic o_log_fault,
    output logic o_log_comm,
    output logic o_debug_mode,
    output logic o_fault_pin_out,
    output logic o_fault_pin_oe
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic fsel_valid(input logic [31:0] sel, input int f);
        fsel_valid = sel[f*FSEL_W+FSEL_VALID_BIT];
    endfunction : fsel_valid

    function automatic logic [PIN_IDX_W-1:0] fsel_pin(input logic [31:0] sel, input int f);
        fsel_pin = sel[f*FSEL_W +: PIN_IDX_W];
    endfunction : fsel_pin

    function automatic logic func_level(input logic [31:0] sel, input int f,
                                        input logic [NUM_PINS-1:0] asrt);
        func_level = fsel_valid(sel, f) & asrt[fsel_pin(sel, f)];
    endfunction : func_level

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    logic [NUM_PINS-1:0] polarity_q;
    logic [NUM_PINS-1:0] fault_en_q;
    logic [NUM_PINS-1:0] shdn_en_q;
    logic [31:0] func_sel_q;
    logic [NUM_RAILS-1:0] shdn_rails_q [NUM_PINS];
    logic [NUM_RAILS-1:0] fault_rails_q;
    logic [1:0] fault_resp_q;
    logic fault_pin_od_q;
    logic fault_pin_pol_q;

    logic wr_hit_func;
    logic [31:0] func_sel_d;

    // a function already claimed keeps its pin until released
    always_comb
    begin
        func_sel_d = func_sel_q;
        for (int f = 0; f < FSEL_NUM; f++)
        begin
            if (wr_hit_func && !i_wdata[f*FSEL_W+FSEL_VALID_BIT])
                func_sel_d[f*FSEL_W +: FSEL_W] = '0;
            else if (wr_hit_func && !fsel_valid(func_sel_q, f))
                func_sel_d[f*FSEL_W +: FSEL_W] = i_wdata[f*FSEL_W +: FSEL_W];
        end
    end

    assign wr_hit_func = i_wr && (i_addr == REG_FUNC_SEL);

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            polarity_q <= RST_POLARITY;
            fault_en_q <= '0;
            shdn_en_q <= '0;
            func_sel_q <= RST_ZERO;
            fault_rails_q <= '0;
            fault_resp_q <= '0;
            fault_pin_od_q <= 1'b0;
            fault_pin_pol_q <= 1'b0;
        end
        else if (i_wr)
        begin
            unique case (i_addr)
                REG_POLARITY: polarity_q <= i_wdata[NUM_PINS-1:0];
                REG_FAULT_EN: fault_en_q <= i_wdata[NUM_PINS-1:0];
                REG_SHDN_EN: shdn_en_q <= i_wdata[NUM_PINS-1:0];
                REG_FUNC_SEL: func_sel_q <= func_sel_d;
                REG_FAULT_RAILS:
                begin
                    fault_rails_q <= i_wdata[NUM_RAILS-1:0];
                    fault_pin_od_q <= i_wdata[NUM_RAILS];
                    fault_pin_pol_q <= i_wdata[NUM_RAILS+1];
                end
                REG_FAULT_RESP: fault_resp_q <= i_wdata[1:0];
                default: ;
            endcase
        end
    end

    // per-pin shutdown rail masks, one word per pin, 4 bytes apart from the pin0 offset
    logic [ADDR_W-1:0] shdn_off;
    logic shdn_hit;
    assign shdn_off = i_addr - REG_SHDN_RAILS0;
    assign shdn_hit = (shdn_off[7:5] == 3'h0) && (shdn_off[1:0] == 2'h0);
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            for (int p = 0; p < NUM_PINS; p++)
                shdn_rails_q[p] <= '0;
        end
        else if (i_wr && shdn_hit)
            shdn_rails_q[shdn_off[4:2]] <= i_wdata[NUM_RAILS-1:0];
    end

    // ----------------------------------------
    // pin sampling
    // ----------------------------------------
    logic [NUM_PINS-1:0] pin_asserted;
    logic [NUM_PINS-1:0] pin_deassert;

    gsf_pin_sync u_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_pins(i_pins),
        .i_active_high(polarity_q),
        .o_asserted(pin_asserted),
        .o_deassert_pulse(pin_deassert)
    );

    logic clear_pin;
    logic margin_en;
    logic margin_low_sel;
    logic debug_mode;

    assign clear_pin = func_level(func_sel_q, FSEL_CLEAR, pin_asserted);
    assign margin_en = func_level(func_sel_q, FSEL_MARGIN_EN, pin_asserted);
    assign margin_low_sel = func_level(func_sel_q, FSEL_MARGIN_LOW, pin_asserted);
    assign debug_mode = func_level(func_sel_q, FSEL_DEBUG, pin_asserted);

    assign o_state_select = pin_asserted[SEL_PINS-1:0];
    assign o_debug_mode = debug_mode;

    // ----------------------------------------
    // pin faults and shutdown
    // ----------------------------------------
    logic [NUM_PINS-1:0] pin_fault_ev;
    logic [NUM_RAILS-1:0] shdn_req;
    logic pin_fault_q;
    logic [NUM_RAILS-1:0] shutdown_q;
    logic delayed_q;

    assign pin_fault_ev = pin_deassert & fault_en_q;

    always_comb
    begin
        shdn_req = '0;
        for (int p = 0; p < NUM_PINS; p++)
        begin
            if (pin_fault_ev[p] && shdn_en_q[p])
                shdn_req = shdn_req | shdn_rails_q[p];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            pin_fault_q <= 1'b0;
        else
            pin_fault_q <= |pin_fault_ev;
    end

    // shutdown holds until software releases it; no retry sequence exists
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            shutdown_q <= '0;
            delayed_q <= 1'b0;
        end
        else
        begin
            if (!debug_mode && fault_resp_q != GSF_RESP_IGNORE && |shdn_req)
            begin
                shutdown_q <= shutdown_q | shdn_req;
                delayed_q <= (fault_resp_q == GSF_RESP_DELAYED);
            end
            else if (i_wr && i_addr == REG_SHDN_STS)
                shutdown_q <= shutdown_q & ~i_wdata[NUM_RAILS-1:0];
        end
    end

    assign o_pin_fault = pin_fault_q;
    assign o_rail_shutdown = shutdown_q;
    assign o_shutdown_delayed = delayed_q;
    assign o_retry_allowed = 1'b0;

    // ----------------------------------------
    // latched status
    // ----------------------------------------
    logic [NUM_RAILS-1:0] latch_q;
    logic [NUM_RAILS-1:0] latch_clr;

    always_comb
    begin
        latch_clr = '0;
        if (clear_pin)
            latch_clr = '1;
        else if (i_wr && i_addr == REG_LATCH_CLR)
            latch_clr = i_wdata[NUM_RAILS-1:0];
    end

    // a new event in the clearing cycle survives
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            latch_q <= '0;
        else
            latch_q <= (latch_q & ~latch_clr) | i_rail_latch_set;
    end

    assign o_latched_status = latch_q;

    // ----------------------------------------
    // margining
    // ----------------------------------------
    gsf_margin_t margin_state;
    logic [NUM_RAILS-1:0] mlow_q;
    logic [NUM_RAILS-1:0] mhigh_q;

    always_comb
    begin
        if (!margin_en)
            margin_state = GSF_MARGIN_NOMINAL;
        else if (margin_low_sel)
            margin_state = GSF_MARGIN_LOW;
        else
            margin_state = GSF_MARGIN_HIGH;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            mlow_q <= '0;
            mhigh_q <= '0;
        end
        else
        begin
            mlow_q <= (margin_state == GSF_MARGIN_LOW) ? i_rail_margin_en : '0;
            mhigh_q <= (margin_state == GSF_MARGIN_HIGH) ? i_rail_margin_en : '0;
        end
    end

    assign o_margin_low = mlow_q;
    assign o_margin_high = mhigh_q;

    // ----------------------------------------
    // debug suppression of alert, response and logging
    // ----------------------------------------
    logic alert_q;
    logic log_q;
    logic comm_q;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            alert_q <= 1'b0;
            log_q <= 1'b0;
            comm_q <= 1'b0;
        end
        else
        begin
            alert_q <= (!debug_mode && (i_fault_event || i_fault_warn || |pin_fault_ev))
                       || i_comm_fault;
            log_q <= !debug_mode && (i_fault_event || |pin_fault_ev);
            comm_q <= i_comm_fault;
        end
    end

    assign o_bus_alert = alert_q;
    assign o_fault_resp_en = !debug_mode;
    assign o_log_fault = log_q;
    assign o_log_comm = comm_q;

    // ----------------------------------------
    // fault indication pin
    // ----------------------------------------
    logic fpin_level_q;
    logic fpin_level_d;

    // level is the active result mapped through output polarity
    assign fpin_level_d = (|(i_rail_fault & fault_rails_q)) ~^ fault_pin_pol_q;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            fpin_level_q <= 1'b1;
        else
            fpin_level_q <= fpin_level_d;
    end

    // open drain never drives high: pull-up supplies it
    assign o_fault_pin_out = fault_pin_od_q ? 1'b0 : fpin_level_q;
    assign o_fault_pin_oe = fault_pin_od_q ? !fpin_level_q : 1'b1;

    // ----------------------------------------
    // read back
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_rdata <= '0;
        else if (i_rd)
        begin
            o_rdata <= '0;
            unique case (i_addr)
                REG_POLARITY: o_rdata[NUM_PINS-1:0] <= polarity_q;
                REG_FAULT_EN: o_rdata[NUM_PINS-1:0] <= fault_en_q;
                REG_SHDN_EN: o_rdata[NUM_PINS-1:0] <= shdn_en_q;
                REG_FUNC_SEL: o_rdata <= func_sel_q;
                REG_FAULT_RAILS: o_rdata[NUM_RAILS+1:0] <=
                    {fault_pin_pol_q, fault_pin_od_q, fault_rails_q};
                REG_PIN_STATE: o_rdata[NUM_PINS-1:0] <= pin_asserted;
                REG_LATCH_STS: o_rdata[NUM_RAILS-1:0] <= latch_q;
                REG_MARGIN: o_rdata[3:0] <= {debug_mode, margin_low_sel, margin_en, clear_pin};
                REG_SHDN_STS: o_rdata[NUM_RAILS-1:0] <= shutdown_q;
                REG_FAULT_RESP: o_rdata[1:0] <= fault_resp_q;
                default:
                begin
                    if (shdn_hit)
                        o_rdata[NUM_RAILS-1:0] <= shdn_rails_q[shdn_off[4:2]];
                end
            endcase
        end
    end
endmodule : gsf_special_inputs

/* verif/gsf_board_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// board side: input pin drivers, fault line pull-up
// ----------------------------------------
module gsf_board_model
    import gsf_pkg::*;
(
    input wire logic i_clk,
    input wire logic [gsf_pkg::NUM_PINS-1:0] i_level,
    input wire logic i_fault_out,
    input wire logic i_fault_oe,
    output logic [gsf_pkg::NUM_PINS-1:0] o_pins,
    output logic o_fault_line
);
    // pins move just after an edge, so the sync stages see a clean step
    always_ff @(posedge i_clk)
    begin
        o_pins <= i_level;
    end

    // a released line floats to the external pull-up
    assign o_fault_line = i_fault_oe ? i_fault_out : 1'b1;
endmodule : gsf_board_model

/* verif/gsf_special_inputs_checker.sv */
`timescale 1ns/100ps
module gsf_special_inputs_checker
    import gsf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [gsf_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_wr,
    input wire logic [gsf_pkg::NUM_RAILS-1:0] i_rail_latch_set,
    input wire logic i_comm_fault,
    input wire logic [gsf_pkg::NUM_RAILS-1:0] o_latched_status,
    input wire logic [gsf_pkg::NUM_RAILS-1:0] o_margin_low,
    input wire logic [gsf_pkg::NUM_RAILS-1:0] o_margin_high,
    input wire logic [gsf_pkg::NUM_RAILS-1:0] o_rail_shutdown,
    input wire logic o_retry_allowed,
    input wire logic o_pin_fault,
    input wire logic o_bus_alert,
    input wire logic o_log_fault,
    input wire logic o_log_comm,
    input wire logic o_debug_mode,
    input wire logic o_fault_resp_en
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence s_pin_evt;
        o_pin_fault ##0 !o_debug_mode;
    endsequence
    sequence s_evt_out;
        o_bus_alert && o_log_fault;
    endsequence

    property p_no_retry;
        !o_retry_allowed;
    endproperty
    property p_dbg_resp;
        o_debug_mode |-> !o_fault_resp_en;
    endproperty
    property p_margin_excl;
        (o_margin_low & o_margin_high) == '0;
    endproperty
    property p_shdn_sticky;
        |($past(o_rail_shutdown) & ~o_rail_shutdown)
            |-> $past(i_wr) && ($past(i_addr) == REG_SHDN_STS);
    endproperty
    property p_latch_set;
        |i_rail_latch_set |=> (o_latched_status & $past(i_rail_latch_set))
            == $past(i_rail_latch_set);
    endproperty
    property p_comm_log;
        i_comm_fault |=> o_log_comm;
    endproperty
    property p_pin_evt;
        s_pin_evt |-> s_evt_out;
    endproperty
    property p_dbg_shdn;
        $past(o_debug_mode) && o_debug_mode
            |-> (o_rail_shutdown & ~$past(o_rail_shutdown)) == '0;
    endproperty
    property p_dbg_log;
        $past(o_debug_mode) && o_debug_mode |-> !o_log_fault;
    endproperty
    // comm faults still raise the alert in debug
    property p_dbg_alert;
        $past(o_debug_mode) && o_debug_mode && !$past(i_comm_fault) |-> !o_bus_alert;
    endproperty

    a_no_retry: assert property (p_no_retry)
        else $error("retry allowed after pin fault");
    a_dbg_resp: assert property (p_dbg_resp)
        else $error("fault response enabled in debug");
    a_margin_excl: assert property (p_margin_excl)
        else $error("rail margined low and high at once");
    a_shdn_sticky: assert property (p_shdn_sticky)
        else $error("shutdown bit dropped without clear write");
    a_latch_set: assert property (p_latch_set)
        else $error("latched status not set");
    a_comm_log: assert property (p_comm_log)
        else $error("comm fault not logged");
    a_pin_evt: assert property (p_pin_evt)
        else $error("pin fault without alert and log");
    a_dbg_shdn: assert property (p_dbg_shdn)
        else $error("shutdown taken in debug");
    a_dbg_log: assert property (p_dbg_log)
        else $error("fault logged in debug");
    a_dbg_alert: assert property (p_dbg_alert)
        else $error("fault alert raised in debug");
endmodule : gsf_special_inputs_checker

bind gsf_special_inputs gsf_special_inputs_checker u_chk (.i_clk, .i_arst_n, .i_addr, .i_wr,
    .i_rail_latch_set, .i_comm_fault, .o_latched_status, .o_margin_low, .o_margin_high,
    .o_rail_shutdown, .o_retry_allowed, .o_pin_fault, .o_bus_alert, .o_log_fault,
    .o_log_comm, .o_debug_mode, .o_fault_resp_en);

/* verif/gsf_special_inputs_tb.sv */
`timescale 1ns/100ps
module gsf_special_inputs_tb;
    import gsf_pkg::*;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [7:0] i_pins, level = 8'h00;
    logic [15:0] i_rail_fault = 16'h0, i_rail_latch_set = 16'h0, i_rail_margin_en = 16'h0;
    logic i_comm_fault = 1'b0, i_fault_event = 1'b0, i_fault_warn = 1'b0;
    logic [15:0] o_latched_status, o_margin_low, o_margin_high, o_rail_shutdown;
    logic [2:0] o_state_select;
    logic o_retry_allowed, o_pin_fault, o_bus_alert, o_fault_resp_en, o_log_fault;
    logic o_log_comm, o_debug_mode, o_fault_pin_out, o_fault_pin_oe, fault_line, o_shutdown_delayed;
    int n_errors = 0;
    int samples_checked = 0;

    always #2.5 i_clk = ~i_clk;

    gsf_special_inputs dut (.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_pins, .i_rail_fault, .i_rail_latch_set, .i_rail_margin_en,
        .i_fault_event, .i_fault_warn, .i_comm_fault, .o_latched_status,
        .o_margin_low, .o_margin_high, .o_rail_shutdown, .o_shutdown_delayed,
        .o_retry_allowed, .o_state_select, .o_pin_fault, .o_bus_alert, .o_fault_resp_en,
        .o_log_fault, .o_log_comm, .o_debug_mode, .o_fault_pin_out, .o_fault_pin_oe);

    gsf_board_model board (.i_clk, .i_level(level), .i_fault_out(o_fault_pin_out),
        .i_fault_oe(o_fault_pin_oe), .o_pins(i_pins), .o_fault_line(fault_line));

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask : rd

    // level changes need sync stages plus one board flop to land
    task pins(input logic [7:0] v);
        @(posedge i_clk);
        level <= v;
        cyc(7);
    endtask : pins

    // one-cycle pulse on {comm, warn, event}, looked at once it has landed
    task pulse(input logic [2:0] v);
        @(posedge i_clk);
        {i_comm_fault, i_fault_warn, i_fault_event} <= v;
        @(posedge i_clk);
        {i_comm_fault, i_fault_warn, i_fault_event} <= 3'h0;
        #1;
    endtask : pulse

    task tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #20000;
        n_errors++;
        tally_and_finish();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        cyc(3);
        i_arst_n <= 1'b1;
        rd(REG_POLARITY, 32'h0000_00FF);
        rd(8'hFC, 32'h0);
        chk(32'({o_fault_pin_oe, o_fault_pin_out}), 32'h3);
        pins(8'h05);
        chk(32'(o_state_select), 32'h5);
        rd(REG_PIN_STATE, 32'h0000_0005);
        wr(REG_POLARITY, 32'h0000_00FE);
        pins(8'h05);
        chk(32'(o_state_select), 32'h4);
        wr(REG_POLARITY, 32'h0000_00FF);
        // clear pin5, margin en pin3, margin low pin4
        wr(REG_FUNC_SEL, 32'h0000_0CBD);
        wr(REG_FUNC_SEL, 32'h0000_0CBF);
        rd(REG_FUNC_SEL, 32'h0000_0CBD);
        @(posedge i_clk) i_rail_margin_en <= 16'h00FF;
        pins(8'h0D);
        chk({o_margin_low, o_margin_high}, 32'h0000_00FF);
        pins(8'h1D);
        chk({o_margin_low, o_margin_high}, 32'h00FF_0000);
        pins(8'h15);
        chk({o_margin_low, o_margin_high}, 32'h0);
        @(posedge i_clk) i_rail_latch_set <= 16'h00F0;
        @(posedge i_clk) i_rail_latch_set <= 16'h0;
        cyc(4);
        chk(32'(o_latched_status), 32'h00F0);
        pins(8'h25);
        chk(32'(o_latched_status), 32'h0);
        pins(8'h05);
        @(posedge i_clk) i_rail_latch_set <= 16'h0003;
        @(posedge i_clk) i_rail_latch_set <= 16'h0;
        wr(REG_LATCH_CLR, 32'h0000_0001);
        cyc(1);
        chk(32'(o_latched_status), 32'h0002);
        wr(REG_FAULT_EN, 32'h1);
        wr(REG_SHDN_EN, 32'h1);
        wr(REG_SHDN_RAILS0, 32'h0000_0A0A);
        wr(REG_FAULT_RESP, 32'h1);
        @(posedge i_clk) level <= 8'h04;
        for (int k = 0; k < 12 && o_pin_fault !== 1'b1; k++)
            @(negedge i_clk);
        chk(32'({o_pin_fault, o_bus_alert, o_log_fault}), 32'h7);
        cyc(2);
        chk(32'(o_rail_shutdown), 32'h0A0A);
        chk(32'(o_retry_allowed), 32'h0);
        wr(REG_SHDN_STS, 32'h0000_FFFF);
        cyc(1);
        chk(32'(o_rail_shutdown), 32'h0);
        // ignore response leaves rails up; delayed response is flagged
        wr(REG_FAULT_RESP, 32'h0);
        pins(8'h05);
        pins(8'h04);
        chk(32'(o_rail_shutdown), 32'h0);
        wr(REG_FAULT_RESP, 32'h2);
        pins(8'h05);
        pins(8'h04);
        chk(32'({o_shutdown_delayed, o_rail_shutdown}), 32'h0001_0A0A);
        wr(REG_SHDN_STS, 32'h0000_FFFF);
        cyc(1);
        chk(32'(o_rail_shutdown), 32'h0);
        wr(REG_FUNC_SEL, 32'h0000_ECBD);
        pins(8'h45);
        chk(32'({o_debug_mode, o_fault_resp_en}), 32'h2);
        pins(8'h44);
        chk(32'(o_rail_shutdown), 32'h0);
        pulse(3'h3);
        chk(32'({o_bus_alert, o_log_fault}), 32'h0);
        pulse(3'h4);
        chk(32'({o_log_comm, o_bus_alert}), 32'h3);
        pins(8'h05);
        pulse(3'h1);
        chk(32'({o_bus_alert, o_log_fault}), 32'h3);
        pulse(3'h2);
        chk(32'({o_bus_alert, o_log_fault}), 32'h2);
        // fault pin watches rail 0, open drain, active high
        wr(REG_FAULT_RAILS, 32'h0003_0001);
        cyc(4);
        chk({o_fault_pin_oe, fault_line}, 32'h2);
        @(posedge i_clk) i_rail_fault <= 16'h0001;
        cyc(4);
        chk({o_fault_pin_oe, fault_line}, 32'h1);
        tally_and_finish();
    end
endmodule : gsf_special_inputs_tb
